// ### design/rxfo_defs.svh
`ifndef RXFO_DEFS_SVH
`define RXFO_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define RXFO_ADDR_NCO_LOW    8'hc7
`define RXFO_ADDR_CRC_COUNT  8'hc9
`define RXFO_ADDR_PHASE_ADJ  8'hca
`define RXFO_ADDR_DIV_RATIO  8'hcb
`define RXFO_ADDR_OH_ONE     8'hd2
`define RXFO_ADDR_OH_TWO     8'hd3
`define RXFO_ADDR_OH_THREE   8'hd4
`define RXFO_ADDR_OH_FOUR    8'hd5
`define RXFO_ADDR_SYNC_HEAD  8'hdd
`define RXFO_ADDR_SYNC_TAIL  8'hde

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RXFO_RST_NCO_LOW     8'h5a
`define RXFO_RST_NCO_HIGH    8'h17
`define RXFO_RST_PHASE_ADJ   6'h2c
`define RXFO_RST_DIV_RATIO   6'h15
`define RXFO_RST_SYNC_HEAD   8'h00
`define RXFO_RST_SYNC_TAIL   6'h00

// ---------------------------------------------------------------
// Field positions and limits
// ---------------------------------------------------------------
`define RXFO_CRC_MAX         8'hff
`define RXFO_TAIL_SYNC_LSB   0
`define RXFO_TAIL_SYNC_MSB   1
`define RXFO_TAIL_STUFF_LSB  2
`define RXFO_TAIL_STUFF_MSB  5
`define RXFO_SYNC_FRAMES     2'h2

`endif

// ### design/rxfo_pkg.sv
package rxfo_pkg;

  // Overhead of one received frame, as the deframer hands it over
  typedef struct packed {
    logic [24:1] eoc;
    logic        uib;
    logic        losd;
    logic        segd;
    logic        sega;
    logic [3:0]  stuff;
    logic [9:0]  sync;
  } rxfo_frame_t;

  typedef struct packed {
    logic [7:0]  ncoLow;
    logic [15:0] ncoWord;
    logic        ncoLoad;
    logic [5:0]  phaseAdj;
    logic [5:0]  divRatio;
    logic [7:0]  crcCount;
    logic [7:0]  ohOne;
    logic [7:0]  ohTwo;
    logic [7:0]  ohThree;
    logic [7:0]  ohFour;
    logic [7:0]  syncHead;
    logic [5:0]  syncTail;
    logic [1:0]  matchCnt;
    logic        frameSync;
    logic        frameEvent;
    logic [7:0]  rdData;
  } rxfo_state_t;

endpackage

// ### design/rxfo_regs.sv
// Function
// - Low NCO byte held; full word moves to accumulator on high byte write.
// - Phase adjust alpha is six bits, 5:0, up to 63, reset 2Ch.
// - Division ratio beta is six bits, 5:0, reset 15h.
// - Eight-bit CRC error count saturates at FFh, clears on reset control.
// - Overhead three shows uib, eoc1, losd, eoc24..20.
// - Overhead four shows eoc17, segd, eoc9, sega, stuff bits 1..4.
// - Sync head register writable, bit 7 earliest sync bit, reset 00h.
// - Last two sync bits in bits 1:0, bit 0 the final bit.
// - Expected stuff pattern in bits 5:2, bit 5 the first stuff bit.
// - Reserved addresses in this bank carry no function.
// - Raise a receive frame event at each received frame boundary.
// - Declare frame sync after two consecutive matching frames.
`timescale 1ns/10ps
`include "rxfo_defs.svh"

module rxfo_regs
  import rxfo_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrStrobe,
  input  wire logic        regRdStrobe,
  output logic [7:0]       regRdData,
  input  wire logic        ncoHighWrite,
  input  wire logic [7:0]  ncoHighByte,
  input  wire logic        errCountReset,
  input  wire logic        frameValid,
  input  wire rxfo_frame_t frameIn,
  input  wire logic        frameCrcFail,
  input  wire logic        syncRestart,
  output logic [15:0]      ncoWord,
  output logic             ncoLoad,
  output logic [5:0]       phaseAdjust,
  output logic [5:0]       divideRatio,
  output logic [9:0]       expectedSync,
  output logic [3:0]       expectedStuff,
  output logic             frameSync,
  output logic             frameEvent
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  rxfo_state_t st_r;
  rxfo_state_t st_nxt;

  logic [9:0]  expSync;
  logic [3:0]  expStuff;
  logic        frameMatch;
  logic        wrHit;

  assign expSync  = {st_r.syncHead,
                     st_r.syncTail[`RXFO_TAIL_SYNC_MSB:`RXFO_TAIL_SYNC_LSB]};
  assign expStuff = st_r.syncTail[`RXFO_TAIL_STUFF_MSB:`RXFO_TAIL_STUFF_LSB];
  assign frameMatch = (frameIn.sync == expSync) && (frameIn.stuff == expStuff);
  assign wrHit = regWrStrobe;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.ncoLoad = 1'b0;
    st_nxt.frameEvent = 1'b0;

    // Register writes; read-only and reserved offsets fall through
    if (wrHit) begin
      if (regAddr == `RXFO_ADDR_NCO_LOW) begin
        st_nxt.ncoLow = regWrData;
      end else if (regAddr == `RXFO_ADDR_PHASE_ADJ) begin
        // Bits 7:6 are not stored, so a careless write cannot disturb the loop
        st_nxt.phaseAdj = regWrData[5:0];
      end else if (regAddr == `RXFO_ADDR_DIV_RATIO) begin
        st_nxt.divRatio = regWrData[5:0];
      end else if (regAddr == `RXFO_ADDR_SYNC_HEAD) begin
        st_nxt.syncHead = regWrData;
      end else if (regAddr == `RXFO_ADDR_SYNC_TAIL) begin
        st_nxt.syncTail = regWrData[5:0];
      end else begin
        st_nxt.syncHead = st_r.syncHead;
      end
    end

    // Word commit; the low byte in use is the one held before this cycle
    if (ncoHighWrite) begin
      st_nxt.ncoWord = {ncoHighByte, st_r.ncoLow};
      st_nxt.ncoLoad = 1'b1;
    end

    // Error count: an error in the clearing cycle is kept, not lost
    if (errCountReset) begin
      st_nxt.crcCount = frameValid && frameCrcFail ? 8'h01 : 8'h00;
    end else if (frameValid && frameCrcFail && st_r.crcCount != `RXFO_CRC_MAX) begin
      st_nxt.crcCount = st_r.crcCount + 8'h01;
    end

    // Overhead capture, all four at once
    if (frameValid) begin
      st_nxt.ohOne = {frameIn.eoc[10], frameIn.eoc[8], frameIn.eoc[7],
                      frameIn.eoc[6], frameIn.eoc[5], frameIn.eoc[4],
                      frameIn.eoc[3], frameIn.eoc[2]};
      st_nxt.ohTwo = {frameIn.eoc[19], frameIn.eoc[18], frameIn.eoc[16],
                      frameIn.eoc[15], frameIn.eoc[14], frameIn.eoc[13],
                      frameIn.eoc[12], frameIn.eoc[11]};
      st_nxt.ohThree = {frameIn.uib, frameIn.eoc[1], frameIn.losd,
                        frameIn.eoc[24:20]};
      st_nxt.ohFour = {frameIn.eoc[17], frameIn.segd, frameIn.eoc[9],
                       frameIn.sega, frameIn.stuff};
      st_nxt.frameEvent = 1'b1;
    end

    // Sync acquisition; once declared it holds until a restart
    if (syncRestart) begin
      st_nxt.frameSync = 1'b0;
      st_nxt.matchCnt = 2'h0;
    end else if (frameValid && !st_r.frameSync) begin
      if (!frameMatch) begin
        st_nxt.matchCnt = 2'h0;
      end else if (st_r.matchCnt + 2'h1 >= `RXFO_SYNC_FRAMES) begin
        st_nxt.frameSync = 1'b1;
        st_nxt.matchCnt = `RXFO_SYNC_FRAMES;
      end else begin
        st_nxt.matchCnt = st_r.matchCnt + 2'h1;
      end
    end

    // Read data, one cycle after the strobe; unmapped reads give zero
    if (regRdStrobe) begin
      if (regAddr == `RXFO_ADDR_NCO_LOW) begin
        st_nxt.rdData = st_r.ncoLow;
      end else if (regAddr == `RXFO_ADDR_CRC_COUNT) begin
        st_nxt.rdData = st_r.crcCount;
      end else if (regAddr == `RXFO_ADDR_PHASE_ADJ) begin
        st_nxt.rdData = {2'b00, st_r.phaseAdj};
      end else if (regAddr == `RXFO_ADDR_DIV_RATIO) begin
        st_nxt.rdData = {2'b00, st_r.divRatio};
      end else if (regAddr == `RXFO_ADDR_OH_ONE) begin
        st_nxt.rdData = st_r.ohOne;
      end else if (regAddr == `RXFO_ADDR_OH_TWO) begin
        st_nxt.rdData = st_r.ohTwo;
      end else if (regAddr == `RXFO_ADDR_OH_THREE) begin
        st_nxt.rdData = st_r.ohThree;
      end else if (regAddr == `RXFO_ADDR_OH_FOUR) begin
        st_nxt.rdData = st_r.ohFour;
      end else if (regAddr == `RXFO_ADDR_SYNC_HEAD) begin
        st_nxt.rdData = st_r.syncHead;
      end else if (regAddr == `RXFO_ADDR_SYNC_TAIL) begin
        st_nxt.rdData = {2'b00, st_r.syncTail};
      end else begin
        st_nxt.rdData = 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r            <= '0;
      st_r.ncoLow     <= `RXFO_RST_NCO_LOW;
      st_r.ncoWord    <= {`RXFO_RST_NCO_HIGH, `RXFO_RST_NCO_LOW};
      st_r.phaseAdj   <= `RXFO_RST_PHASE_ADJ;
      st_r.divRatio   <= `RXFO_RST_DIV_RATIO;
      st_r.syncHead   <= `RXFO_RST_SYNC_HEAD;
      st_r.syncTail   <= `RXFO_RST_SYNC_TAIL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all taken from the state register
  // ---------------------------------------------------------------
  assign regRdData     = st_r.rdData;
  assign ncoWord       = st_r.ncoWord;
  assign ncoLoad       = st_r.ncoLoad;
  assign phaseAdjust   = st_r.phaseAdj;
  assign divideRatio   = st_r.divRatio;
  assign expectedSync  = expSync;
  assign expectedStuff = expStuff;
  assign frameSync     = st_r.frameSync;
  assign frameEvent    = st_r.frameEvent;

endmodule

// ### tb/rxfo_chk.sv
`timescale 1ns/10ps
// ------------------------------
// Register bank relations
// ------------------------------
module rxfo_chk (
  input logic        clock,
  input logic        srst,
  input logic [7:0]  regAddr,
  input logic [7:0]  regWrData,
  input logic        regWrStrobe,
  input logic        ncoHighWrite,
  input logic [7:0]  ncoHighByte,
  input logic        frameValid,
  input logic        syncRestart,
  input logic [15:0] ncoWord,
  input logic        ncoLoad,
  input logic [5:0]  phaseAdjust,
  input logic [9:0]  expectedSync,
  input logic [3:0]  expectedStuff,
  input logic        frameSync,
  input logic        frameEvent
);
  default clocking dc @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_wr(a); regWrStrobe && regAddr == a; endsequence
  sequence s_low_commit; s_wr(8'hc7) ##1 !regWrStrobe ##1 ncoHighWrite; endsequence
  property p_commit; ncoHighWrite |=> ncoLoad && ncoWord[15:8] == $past(ncoHighByte); endproperty
  property p_low; s_low_commit |=> ncoWord[7:0] == $past(regWrData, 3); endproperty
  property p_hold; !ncoHighWrite |=> !ncoLoad && $stable(ncoWord); endproperty
  property p_event; 1 |=> frameEvent == $past(frameValid); endproperty
  property p_phase; s_wr(8'hca) |=> phaseAdjust == $past(regWrData[5:0]); endproperty
  property p_head; s_wr(8'hdd) |=> expectedSync[9:2] == $past(regWrData); endproperty
  property p_tail; s_wr(8'hde) |=> {expectedStuff, expectedSync[1:0]} == $past(regWrData[5:0]);
  endproperty
  property p_drop; syncRestart |=> !frameSync; endproperty
  a_commit: assert property (p_commit) else $error("bad commit");
  a_low: assert property (p_low) else $error("bad low byte");
  a_hold: assert property (p_hold) else $error("word moved");
  a_event: assert property (p_event) else $error("bad event");
  a_phase: assert property (p_phase) else $error("bad phase");
  a_head: assert property (p_head) else $error("bad head");
  a_tail: assert property (p_tail) else $error("bad tail");
  a_drop: assert property (p_drop) else $error("sync kept");
endmodule

// ### tb/rxfo_host.sv
`timescale 1ns/10ps
// ------------------------------
// Host on the register port
// ------------------------------
module rxfo_host (
  input  logic       clock,
  input  logic [7:0] regRdData,
  output logic [7:0] regAddr,
  output logic [7:0] regWrData,
  output logic       regWrStrobe,
  output logic       regRdStrobe
);
  initial {regAddr, regWrData, regWrStrobe, regRdStrobe} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= (a inside {8'hca, 8'hcb, 8'hde}) ? d & 8'h3f : d;
    regWrStrobe <= 1'b1;
    @(posedge clock);
    regWrStrobe <= 1'b0;
    // Scrambled on release so stale data cannot pass for a write
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge clock);
    regRdStrobe <= 1'b0;
    #1 d = regRdData;
  endtask
endmodule

// ### tb/tb_rxfo_regs.sv
`timescale 1ns/10ps
// ------------------------------
// Bench
// ------------------------------
module tb_rxfo_regs
  import rxfo_pkg::*;
;
  logic        clock = 1'b0, srst = 1'b1, ncoHighWrite = 1'b0, errCountReset = 1'b0;
  logic        frameValid = 1'b0, frameCrcFail = 1'b0, syncRestart = 1'b0;
  logic [7:0]  ncoHighByte = 8'h00, regAddr, regWrData, regRdData, d;
  logic        regWrStrobe, regRdStrobe, ncoLoad, frameSync, frameEvent;
  logic [15:0] ncoWord;
  logic [5:0]  phaseAdjust, divideRatio;
  logic [9:0]  expectedSync;
  logic [3:0]  expectedStuff;
  logic [63:0] rnd;
  rxfo_frame_t fr = '0;
  int          mismatches = 0, cmp_count = 0, seed = 92871, crc = 0, mc = 0, mdl[256];
  logic [7:0]  adr[14] = '{8'hc7, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hd1, 8'hd2, 8'hd5, 8'hd6,
                          8'hdc, 8'hdd, 8'hde, 8'hdf, 8'hff};
  always #2.5 clock = ~clock;
  rxfo_host host_u (.clock, .regRdData, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe);
  rxfo_regs dut_u (.clock, .srst, .regAddr, .regWrData, .regWrStrobe, .regRdStrobe, .regRdData,
    .ncoHighWrite, .ncoHighByte, .errCountReset, .frameValid, .frameIn(fr), .frameCrcFail,
    .syncRestart, .ncoWord, .ncoLoad, .phaseAdjust, .divideRatio, .expectedSync,
    .expectedStuff, .frameSync, .frameEvent);
  task automatic wrap_up();
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a);
    host_u.rd(a, d);
    chk(16'(d), 16'(mdl[a]));
  endtask
  task automatic nco(input logic [7:0] h);
    @(posedge clock);
    ncoHighWrite <= 1'b1;
    ncoHighByte <= h;
    @(posedge clock);
    ncoHighWrite <= 1'b0;
    ncoHighByte <= ~h;
    #1 chk(ncoWord, {h, 8'(mdl[8'hc7])});
  endtask
  // Sync mismatch is forced, since a random field could match by chance
  task automatic frm(input int n, input logic c, input logic m);
    rxfo_frame_t f;
    rnd = {$random(seed), $random(seed)};
    f = rnd[41:0];
    f.sync = {8'(mdl[8'hdd]), 2'(mdl[8'hde])} ^ 10'(!m);
    f.stuff = 4'(mdl[8'hde] >> 2);
    @(posedge clock);
    fr <= f;
    frameValid <= 1'b1;
    frameCrcFail <= c;
    repeat (n) @(posedge clock);
    frameValid <= 1'b0;
    crc = (crc + n * c > 255) ? 255 : crc + n * c;
    mc = (mc >= 2) ? mc : (m ? mc + n : 0);
    mdl[8'hc9] = crc;
    mdl[8'hd2] = {f.eoc[10], f.eoc[8:2]};
    mdl[8'hd3] = {f.eoc[19:18], f.eoc[16:11]};
    mdl[8'hd4] = {f.uib, f.eoc[1], f.losd, f.eoc[24:20]};
    mdl[8'hd5] = {f.eoc[17], f.segd, f.eoc[9], f.sega, f.stuff};
    #1 chk(16'(frameSync), 16'(mc >= 2));
  endtask
  initial begin
    mdl[8'hc7] = 'h5a;
    mdl[8'hca] = 'h2c;
    mdl[8'hcb] = 'h15;
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    foreach (adr[i]) rdc(adr[i]);
    foreach (adr[i]) begin
      rnd = $random(seed);
      host_u.wr(adr[i], rnd[7:0]);
      if (adr[i] inside {8'hc7, 8'hdd}) mdl[adr[i]] = rnd[7:0];
      if (adr[i] inside {8'hca, 8'hcb, 8'hde}) mdl[adr[i]] = rnd[5:0];
      rdc(adr[i]);
    end
    chk(16'(divideRatio), 16'(mdl[8'hcb]));
    chk(16'({expectedStuff, expectedSync}), 16'({mdl[8'hde][5:2], mdl[8'hdd][7:0],
      mdl[8'hde][1:0]}));
    nco(rnd[15:8]);
    repeat (3) begin
      frm(1, 1'($random(seed)), 0);
      for (int a = 'hd2; a <= 'hd5; a++) rdc(8'(a));
      rdc(8'hc9);
    end
    frm(300, 1, 0);
    rdc(8'hc9);
    @(posedge clock);
    errCountReset <= 1'b1;
    @(posedge clock);
    errCountReset <= 1'b0;
    crc = 0;
    frm(2, 0, 0);
    rdc(8'hc9);
    frm(1, 0, 1);
    frm(1, 0, 0);
    frm(2, 0, 1);
    @(posedge clock);
    syncRestart <= 1'b1;
    @(posedge clock);
    syncRestart <= 1'b0;
    #1 chk(16'(frameSync), 16'h0000);
    mc = 0;
    host_u.wr(8'hc7, 8'h5a);
    mdl[8'hc7] = 'h5a;
    nco(8'h17);
    wrap_up();
  end
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    wrap_up();
  end
endmodule
bind rxfo_regs rxfo_chk chk_u (.clock, .srst, .regAddr, .regWrData, .regWrStrobe, .ncoHighWrite,
  .ncoHighByte, .frameValid, .syncRestart, .ncoWord, .ncoLoad, .phaseAdjust, .expectedSync,
  .expectedStuff, .frameSync, .frameEvent);
